// File: design/oam_unit.sv
// Operand addressing unit: turns one 6-bit operand specifier into an operand
// or an effective address, stepping registers and the program counter.
// Assumes the bus interface answers MEM_RD with a one-cycle MEM_ACK on CORE_CLK
// and that the program counter already points past the instruction word.
`timescale 1ns/1ps
`default_nettype none

module oam_unit #(
  parameter int DATA_W = oam_pkg::DATA_W
) (
  input  wire logic              CORE_CLK,
  input  wire logic              RESETN,
  input  wire logic              START,
  input  wire logic [5:0]        SPEC,
  input  wire logic              BYTE_OP,
  output logic                   BUSY,
  output logic                   DONE,
  output logic      [DATA_W-1:0] EA,
  output logic      [DATA_W-1:0] OPERAND,
  output logic                   OPERAND_VALID,
  output logic                   OPERAND_IN_REG,
  output logic                   MEM_RD,
  output logic      [DATA_W-1:0] MEM_ADDR,
  input  wire logic              MEM_ACK,
  input  wire logic [DATA_W-1:0] MEM_RDATA,
  input  wire logic              REG_WE,
  input  wire logic [2:0]        REG_WSEL,
  input  wire logic [DATA_W-1:0] REG_WDATA,
  input  wire logic              SP_PUSH,
  input  wire logic              SP_POP,
  output logic      [DATA_W-1:0] PC_OUT,
  output logic      [DATA_W-1:0] SP_OUT
);

  localparam logic [DATA_W-1:0] STEP2 = DATA_W'(oam_pkg::WORD_STEP);
  localparam logic [DATA_W-1:0] STEP1 = DATA_W'(oam_pkg::BYTE_STEP);

  // Specifier field extraction for the mode and register fields of SPEC
  function automatic logic [2:0] spec_mode(input logic [5:0] s);
    return s[oam_pkg::SPEC_MODE_LSB +: 3];
  endfunction

  function automatic logic [2:0] spec_reg(input logic [5:0] s);
    return s[oam_pkg::SPEC_REG_LSB +: 3];
  endfunction

  oam_pkg::oam_state_e state_q;
  oam_pkg::oam_state_e state_d;
  logic [2:0]        mode_q;
  logic [2:0]        mode_d;
  logic [2:0]        sel_q;
  logic [2:0]        sel_d;
  logic              mem_rd_q;
  logic              mem_rd_d;
  logic [DATA_W-1:0] mem_addr_q;
  logic [DATA_W-1:0] mem_addr_d;
  logic [DATA_W-1:0] ea_q;
  logic [DATA_W-1:0] ea_d;
  logic [DATA_W-1:0] opnd_q;
  logic [DATA_W-1:0] opnd_d;
  logic              valid_q;
  logic              valid_d;
  logic              in_reg_q;
  logic              in_reg_d;
  logic              done_q;
  logic              done_d;

  logic              rf_we;
  logic [2:0]        rf_wsel;
  logic [DATA_W-1:0] rf_wdata;
  logic [DATA_W-1:0] rf_rdata;
  logic [DATA_W-1:0] pc;
  logic [DATA_W-1:0] sp;

  wire              idle_w    = (state_q == oam_pkg::OAM_IDLE);
  wire              start_w   = idle_w && START;
  wire [2:0]        new_mode  = spec_mode(SPEC);
  wire [2:0]        new_sel   = spec_reg(SPEC);
  wire [2:0]        rsel_w    = idle_w ? new_sel : sel_q;
  wire              new_is_pc = (new_sel == oam_pkg::PC_SEL);
  wire              ack_w     = mem_rd_q && MEM_ACK;
  // Byte stepping only for plain auto modes on ordinary registers
  wire              small_reg = (new_sel != oam_pkg::SP_SEL) && !new_is_pc;
  wire              auto_md   = (new_mode == oam_pkg::MODE_AINC) ||
                                (new_mode == oam_pkg::MODE_ADEC);
  wire [DATA_W-1:0] step_w    = (BYTE_OP && small_reg && auto_md) ? STEP1 : STEP2;
  wire [DATA_W-1:0] inc_w     = rf_rdata + step_w;
  wire [DATA_W-1:0] dec_w     = rf_rdata - step_w;
  wire [DATA_W-1:0] pc_plus2  = pc + STEP2;
  // With the PC as base the index is added to the already advanced PC
  wire [DATA_W-1:0] base_w    = (sel_q == oam_pkg::PC_SEL) ? pc_plus2 : rf_rdata;
  wire [DATA_W-1:0] idx_sum   = MEM_RDATA + base_w;

  oam_regfile #(
    .DATA_W (DATA_W),
    .REG_N  (oam_pkg::REG_N),
    .SEL_W  (oam_pkg::SEL_W)
  ) u_regs (
    .clk   (CORE_CLK),
    .rst_n (RESETN),
    .we    (rf_we),
    .wsel  (rf_wsel),
    .wdata (rf_wdata),
    .rsel  (rsel_w),
    .rdata (rf_rdata),
    .pc    (pc),
    .sp    (sp)
  );

  // Register write arbitration; the specifier path owns the port while busy
  always_comb begin
    rf_we    = 1'b0;
    rf_wsel  = sel_q;
    rf_wdata = pc_plus2;
    case (state_q)
      oam_pkg::OAM_IDLE: begin
        if (START) begin
          rf_wsel = new_sel;
          if (new_mode == oam_pkg::MODE_AINC && !new_is_pc) begin
            rf_we    = 1'b1;
            rf_wdata = inc_w;
          end else if (new_mode == oam_pkg::MODE_ADEC ||
                       new_mode == oam_pkg::MODE_ADEC_DEF) begin
            rf_we    = 1'b1;
            rf_wdata = dec_w;
          end
        end else if (REG_WE) begin
          rf_we    = 1'b1;
          rf_wsel  = REG_WSEL;
          rf_wdata = REG_WDATA;
        end else if (SP_PUSH) begin
          rf_we    = 1'b1;
          rf_wsel  = oam_pkg::SP_SEL;
          rf_wdata = sp - STEP2;
        end else if (SP_POP) begin
          rf_we    = 1'b1;
          rf_wsel  = oam_pkg::SP_SEL;
          rf_wdata = sp + STEP2;
        end
      end
      oam_pkg::OAM_INDEX, oam_pkg::OAM_IMM: begin
        if (ack_w) begin
          rf_we   = 1'b1;
          rf_wsel = oam_pkg::PC_SEL;
        end
      end
      oam_pkg::OAM_DEFER: begin
        if (ack_w && mode_q == oam_pkg::MODE_AINC_DEF) begin
          rf_we    = 1'b1;
          rf_wdata = rf_rdata + STEP2;
        end
      end
      default: begin
        rf_we = 1'b0;
      end
    endcase
  end

  // Sequencing of address formation and pointer reads
  always_comb begin
    state_d    = state_q;
    mode_d     = mode_q;
    sel_d      = sel_q;
    mem_rd_d   = mem_rd_q;
    mem_addr_d = mem_addr_q;
    ea_d       = ea_q;
    opnd_d     = opnd_q;
    valid_d    = valid_q;
    in_reg_d   = in_reg_q;
    done_d     = 1'b0;
    case (state_q)
      oam_pkg::OAM_IDLE: begin
        if (START) begin
          mode_d   = new_mode;
          sel_d    = new_sel;
          valid_d  = 1'b0;
          in_reg_d = 1'b0;
          case (new_mode)
            oam_pkg::MODE_REG: begin
              opnd_d   = rf_rdata;
              valid_d  = 1'b1;
              in_reg_d = 1'b1;
              done_d   = 1'b1;
            end
            oam_pkg::MODE_REG_DEF: begin
              ea_d   = rf_rdata;
              done_d = 1'b1;
            end
            oam_pkg::MODE_AINC: begin
              if (new_is_pc) begin
                mem_addr_d = pc;
                mem_rd_d   = 1'b1;
                state_d    = oam_pkg::OAM_IMM;
              end else begin
                ea_d   = rf_rdata;
                done_d = 1'b1;
              end
            end
            oam_pkg::MODE_AINC_DEF: begin
              mem_addr_d = rf_rdata;
              mem_rd_d   = 1'b1;
              state_d    = oam_pkg::OAM_DEFER;
            end
            oam_pkg::MODE_ADEC: begin
              ea_d   = dec_w;
              done_d = 1'b1;
            end
            oam_pkg::MODE_ADEC_DEF: begin
              mem_addr_d = dec_w;
              mem_rd_d   = 1'b1;
              state_d    = oam_pkg::OAM_DEFER;
            end
            default: begin
              mem_addr_d = pc;
              mem_rd_d   = 1'b1;
              state_d    = oam_pkg::OAM_INDEX;
            end
          endcase
        end
      end
      oam_pkg::OAM_INDEX: begin
        if (ack_w) begin
          if (mode_q == oam_pkg::MODE_INDEX_DEF) begin
            mem_addr_d = idx_sum;
            state_d    = oam_pkg::OAM_DEFER;
          end else begin
            ea_d     = idx_sum;
            mem_rd_d = 1'b0;
            done_d   = 1'b1;
            state_d  = oam_pkg::OAM_IDLE;
          end
        end
      end
      oam_pkg::OAM_DEFER: begin
        if (ack_w) begin
          ea_d     = MEM_RDATA;
          mem_rd_d = 1'b0;
          done_d   = 1'b1;
          state_d  = oam_pkg::OAM_IDLE;
        end
      end
      oam_pkg::OAM_IMM: begin
        if (ack_w) begin
          ea_d     = mem_addr_q;
          opnd_d   = MEM_RDATA;
          valid_d  = 1'b1;
          mem_rd_d = 1'b0;
          done_d   = 1'b1;
          state_d  = oam_pkg::OAM_IDLE;
        end
      end
      default: begin
        state_d = oam_pkg::OAM_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_q    <= oam_pkg::OAM_IDLE;
      mode_q     <= oam_pkg::MODE_REG;
      sel_q      <= 3'h0;
      mem_rd_q   <= 1'b0;
      mem_addr_q <= DATA_W'(oam_pkg::REG_RESET);
      ea_q       <= DATA_W'(oam_pkg::REG_RESET);
      opnd_q     <= DATA_W'(oam_pkg::REG_RESET);
      valid_q    <= 1'b0;
      in_reg_q   <= 1'b0;
      done_q     <= 1'b0;
    end else begin
      state_q    <= state_d;
      mode_q     <= mode_d;
      sel_q      <= sel_d;
      mem_rd_q   <= mem_rd_d;
      mem_addr_q <= mem_addr_d;
      ea_q       <= ea_d;
      opnd_q     <= opnd_d;
      valid_q    <= valid_d;
      in_reg_q   <= in_reg_d;
      done_q     <= done_d;
    end
  end

  // Idle again in the DONE cycle, so a new request may follow at once
  assign BUSY           = !idle_w;
  assign DONE           = done_q;
  assign EA             = ea_q;
  assign OPERAND        = opnd_q;
  assign OPERAND_VALID  = valid_q;
  assign OPERAND_IN_REG = in_reg_q;
  assign MEM_RD         = mem_rd_q;
  assign MEM_ADDR       = mem_addr_q;
  assign PC_OUT         = pc;
  assign SP_OUT         = sp;

endmodule

`default_nettype wire

// File: design/oam_pkg.sv
// Constants and types shared by the operand addressing unit and its register file.
// Assumes a 16-bit word machine with eight general registers.
package oam_pkg;

  localparam int DATA_W = 16;
  localparam int REG_N  = 8;
  localparam int SEL_W  = 3;
  localparam int SPEC_W = 6;

  // Operand specifier layout: mode in the upper three bits, register below
  localparam int SPEC_MODE_LSB = 3;
  localparam int SPEC_REG_LSB  = 0;

  localparam logic [2:0] MODE_REG       = 3'h0;
  localparam logic [2:0] MODE_REG_DEF   = 3'h1;
  localparam logic [2:0] MODE_AINC      = 3'h2;
  localparam logic [2:0] MODE_AINC_DEF  = 3'h3;
  localparam logic [2:0] MODE_ADEC      = 3'h4;
  localparam logic [2:0] MODE_ADEC_DEF  = 3'h5;
  localparam logic [2:0] MODE_INDEX     = 3'h6;
  localparam logic [2:0] MODE_INDEX_DEF = 3'h7;

  localparam logic [2:0] SP_SEL = 3'h6;
  localparam logic [2:0] PC_SEL = 3'h7;

  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam logic [15:0] BYTE_STEP = 16'h0001;
  localparam logic [15:0] REG_RESET = 16'h0000;

  typedef enum logic [1:0] {
    OAM_IDLE,
    OAM_INDEX,
    OAM_DEFER,
    OAM_IMM
  } oam_state_e;

endpackage

// File: design/oam_regfile.sv
// Eight general registers, one write port, one selectable read port.
// Assumes the owner grants at most one write per cycle.
`timescale 1ns/1ps
`default_nettype none

module oam_regfile #(
  parameter int DATA_W = oam_pkg::DATA_W,
  parameter int REG_N  = oam_pkg::REG_N,
  parameter int SEL_W  = oam_pkg::SEL_W
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              we,
  input  wire logic [SEL_W-1:0]  wsel,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [SEL_W-1:0]  rsel,
  output logic      [DATA_W-1:0] rdata,
  output logic      [DATA_W-1:0] pc,
  output logic      [DATA_W-1:0] sp
);

  logic [DATA_W-1:0] regs_q [REG_N];

  generate
    for (genvar i = 0; i < REG_N; i++) begin : g_reg
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          regs_q[i] <= DATA_W'(oam_pkg::REG_RESET);
        end else if (we && (wsel == SEL_W'(i))) begin
          regs_q[i] <= wdata;
        end
      end
    end
  endgenerate

  assign rdata = regs_q[rsel];
  assign pc    = regs_q[oam_pkg::PC_SEL];
  assign sp    = regs_q[oam_pkg::SP_SEL];

endmodule

`default_nettype wire

// File: tb/oam_unit_asserts.sv
// Port-level checker for the operand addressing unit.
// Bound into every oam_unit; watches only its ports.
`timescale 1ns/1ps
`default_nettype none
module oam_unit_asserts #(
  parameter int DATA_W = 16
) (
  input wire logic              CORE_CLK,
  input wire logic              RESETN,
  input wire logic              START,
  input wire logic [5:0]        SPEC,
  input wire logic              BUSY,
  input wire logic              DONE,
  input wire logic [DATA_W-1:0] EA,
  input wire logic [DATA_W-1:0] OPERAND,
  input wire logic              OPERAND_VALID,
  input wire logic              OPERAND_IN_REG,
  input wire logic              MEM_RD,
  input wire logic [DATA_W-1:0] MEM_ADDR,
  input wire logic              MEM_ACK,
  input wire logic [DATA_W-1:0] MEM_RDATA,
  input wire logic [DATA_W-1:0] PC_OUT,
  input wire logic [DATA_W-1:0] SP_OUT
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  wire logic take = START && !BUSY;
  sequence s_ack;
    MEM_RD && MEM_ACK;
  endsequence
  // First matching ack in the window is the final read for these modes
  // Final read's data must show up with DONE, together with flag f
  sequence s_final(logic [DATA_W-1:0] v, logic f);
    ##[1:40] s_ack ##1 (DONE && f && v == $past(MEM_RDATA));
  endsequence
  a_reg_direct: assert property (
    take && SPEC[5:3] == 3'h0 |=> DONE && OPERAND_IN_REG && !MEM_RD)
    else $error("register mode slow or touched memory");
  a_sp_defer: assert property (
    take && SPEC == 6'h0E |=> DONE && EA == $past(SP_OUT) && $stable(SP_OUT))
    else $error("register deferred address wrong");
  a_sp_ainc: assert property (
    take && SPEC == 6'h16 |=> EA == $past(SP_OUT) && SP_OUT == $past(SP_OUT) + 16'h0002)
    else $error("stack autoincrement wrong");
  a_sp_adec: assert property (
    take && SPEC == 6'h26 |=> SP_OUT == $past(SP_OUT) - 16'h0002 && EA == SP_OUT)
    else $error("stack autodecrement wrong");
  a_index_fetch: assert property (
    take && SPEC[5:4] == 2'h3 |=> MEM_RD && MEM_ADDR == $past(PC_OUT))
    else $error("index word not read at program counter");
  a_pc_step: assert property (
    MEM_RD && MEM_ACK && MEM_ADDR == PC_OUT |=> PC_OUT == $past(PC_OUT) + 16'h0002)
    else $error("program counter not stepped after fetch");
  a_imm_operand: assert property (
    take && SPEC == 6'h17 |-> s_final(OPERAND, OPERAND_VALID))
    else $error("immediate operand wrong");
  a_defer_ea: assert property (
    take && (SPEC[5:3] == 3'h3 || SPEC[5:3] == 3'h5) |-> s_final(EA, 1'b1))
    else $error("deferred address not taken from memory");
  a_rd_hold: assert property (
    MEM_RD && !MEM_ACK |=> MEM_RD && $stable(MEM_ADDR))
    else $error("read request dropped or moved before ack");
endmodule
bind oam_unit oam_unit_asserts #(.DATA_W(DATA_W)) u_chk (
  .CORE_CLK(CORE_CLK), .RESETN(RESETN), .START(START), .SPEC(SPEC), .BUSY(BUSY),
  .DONE(DONE), .EA(EA), .OPERAND(OPERAND), .OPERAND_VALID(OPERAND_VALID),
  .OPERAND_IN_REG(OPERAND_IN_REG), .MEM_RD(MEM_RD), .MEM_ADDR(MEM_ADDR),
  .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA), .PC_OUT(PC_OUT), .SP_OUT(SP_OUT));
`default_nettype wire

// File: tb/oam_mem_model.sv
// Memory behind the bus interface: word at address A reads A xor A5A5.
// Assumes one outstanding read; lat sets extra wait cycles.
`timescale 1ns/1ps
`default_nettype none
module oam_mem_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        rd,
  input  wire logic [15:0] addr,
  input  wire logic [3:0]  lat,
  output logic             ack,
  output logic      [15:0] rdata
);
  logic [3:0] wait_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack    <= 1'b0;
      rdata  <= 16'h0000;
      wait_q <= 4'h0;
    end else begin
      ack   <= 1'b0;
      // Data is only good with ack; toggling exposes late sampling
      rdata <= ~rdata;
      if (rd && !ack && wait_q == lat) begin
        ack    <= 1'b1;
        rdata  <= addr ^ 16'hA5A5;
        wait_q <= 4'h0;
      end else if (rd && !ack) begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for the operand addressing unit.
// Assumes the memory model answers every read.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk, rst_n, start, byte_op, busy, done, op_valid, in_reg;
  logic        mem_rd, mem_ack, reg_we, sp_push, sp_pop;
  logic [5:0]  spec;
  logic [2:0]  wsel;
  logic [3:0]  lat;
  logic [15:0] ea, operand, mem_addr, mem_rdata, wdata, pc, sp;
  int          err_total, num_checks;
  oam_unit dut (.CORE_CLK(clk), .RESETN(rst_n), .START(start), .SPEC(spec), .BYTE_OP(byte_op),
    .BUSY(busy), .DONE(done), .EA(ea), .OPERAND(operand), .OPERAND_VALID(op_valid),
    .OPERAND_IN_REG(in_reg), .MEM_RD(mem_rd), .MEM_ADDR(mem_addr), .MEM_ACK(mem_ack),
    .MEM_RDATA(mem_rdata), .REG_WE(reg_we), .REG_WSEL(wsel), .REG_WDATA(wdata),
    .SP_PUSH(sp_push), .SP_POP(sp_pop), .PC_OUT(pc), .SP_OUT(sp));
  oam_mem_model mem (.clk(clk), .rst_n(rst_n), .rd(mem_rd), .addr(mem_addr), .lat(lat),
    .ack(mem_ack), .rdata(mem_rdata));
  function automatic logic [15:0] mf(input logic [15:0] a);
    return a ^ 16'hA5A5;
  endfunction
  task automatic end_of_test();
    if (err_total == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic op(input logic [5:0] s, input logic b);
    @(posedge clk);
    #1;
    start   = 1'b1;
    spec    = s;
    byte_op = b;
    @(posedge clk);
    #1;
    start = 1'b0;
    for (int i = 0; i < 60 && done !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (done !== 1'b1) begin
      err_total++;
      $display("ERROR %0t no done within bound", $time);
      end_of_test();
    end
  endtask
  task automatic wr(input logic [2:0] s, input logic [15:0] d);
    @(posedge clk);
    #1;
    reg_we = 1'b1;
    wsel   = s;
    wdata  = d;
    @(posedge clk);
    #1;
    reg_we = 1'b0;
  endtask
  task automatic t_modes();
    logic [15:0] st, t, er, ep, ee;
    logic [2:0]  m;
    for (int k = 0; k < 16; k++) begin
      m   = k[2:0];
      lat = m[0] ? 4'h3 : 4'h0;
      st  = k[3] ? oam_pkg::BYTE_STEP : oam_pkg::WORD_STEP;
      wr(3'h2, 16'h0100);
      wr(3'h7, 16'h0200);
      op({m, 3'h2}, k[3]);
      er = m == 2 ? 16'h0100 + st : m == 3 ? 16'h0102 : m == 4 ? 16'h0100 - st
         : m == 5 ? 16'h00FE : 16'h0100;
      t  = m[2] && !m[1] ? er : 16'h0100;
      ee = m == 3 || m == 5 ? mf(t) : m == 6 ? mf(16'h0200) + 16'h0100
         : m == 7 ? mf(mf(16'h0200) + 16'h0100) : t;
      ep = m[2] && m[1] ? 16'h0202 : 16'h0200;
      if (m == 0) chk(operand, 16'h0100);
      if (m == 0) chk(16'(in_reg), 16'h0001);
      if (m != 0) chk(ea, ee);
      chk(pc, ep);
      op(6'h02, 1'b0);
      chk(operand, er);
    end
  endtask
  task automatic t_pcmodes();
    logic [2:0]  m;
    logic [15:0] x;
    for (int i = 0; i < 4; i++) begin
      m   = {i[1], 1'b1, i[0]};
      lat = i[0] ? 4'h2 : 4'h0;
      wr(3'h7, 16'h0300);
      op({m, 3'h7}, 1'b0);
      x = mf(16'h0300) + (m[2] ? 16'h0302 : 16'h0000);
      chk(ea, m == 2 ? 16'h0300 : m == 7 ? mf(x) : x);
      if (m == 2) chk(operand, mf(16'h0300));
      if (m == 2) chk(16'(op_valid), 16'h0001);
      chk(pc, 16'h0302);
    end
  endtask
  task automatic t_stack();
    wr(3'h6, 16'h0400);
    op(6'h16, 1'b1);
    chk(ea, 16'h0400);
    chk(sp, 16'h0402);
    op(6'h26, 1'b1);
    chk(sp, 16'h0400);
    chk(ea, 16'h0400);
    op(6'h0E, 1'b1);
    chk(ea, 16'h0400);
    @(posedge clk);
    #1;
    sp_push = 1'b1;
    @(posedge clk);
    #1;
    sp_push = 1'b0;
    sp_pop  = 1'b1;
    chk(sp, 16'h03FE);
    @(posedge clk);
    #1;
    sp_pop = 1'b0;
    chk(sp, 16'h0400);
  endtask
  task automatic t_b2b();
    wr(3'h3, 16'h0033);
    wr(3'h4, 16'h0044);
    @(posedge clk);
    #1;
    start = 1'b1;
    spec  = 6'h03;
    @(posedge clk);
    #1;
    chk(16'(done), 16'h0001);
    chk(operand, 16'h0033);
    spec = 6'h04;
    @(posedge clk);
    #1;
    start = 1'b0;
    chk(16'(done), 16'h0001);
    chk(operand, 16'h0044);
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    {rst_n, start, byte_op, reg_we, sp_push, sp_pop, spec, wsel, lat, wdata} = '0;
    err_total  = 0;
    num_checks = 0;
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk(pc, 16'h0000);
    chk(16'(busy), 16'h0000);
    t_modes();
    t_pcmodes();
    t_stack();
    t_b2b();
    end_of_test();
  end
endmodule
`default_nettype wire
